// ===== rtl/pit_pkg.sv
package pit_pkg;
	// Register offsets: printed offsets are not all multiples of four, so they are indices
	localparam logic [7:0] PIT_IDX_STATUS_CONTROL = 8'h4B;
	localparam logic [7:0] PIT_IDX_COUNT_HIGH     = 8'h4C;
	localparam logic [7:0] PIT_IDX_COUNT_LOW      = 8'h4D;
	localparam logic [7:0] PIT_IDX_MODULO_HIGH    = 8'h4E;
	localparam logic [7:0] PIT_IDX_MODULO_LOW     = 8'h4F;
	localparam logic [7:0] PIT_IDX_MODE_CONTROL   = 8'h50;
	localparam int         PIT_ADDR_W             = 12;
	// Status/control fields
	localparam int PIT_BIT_OVERFLOW  = 7;
	localparam int PIT_BIT_IRQ_EN    = 6;
	localparam int PIT_BIT_HALT      = 5;
	localparam int PIT_BIT_CLEAR     = 4;
	localparam int PIT_PS_MSB        = 2;
	// Mode control fields
	localparam int PIT_BIT_WAIT      = 0;
	localparam int PIT_BIT_STOP      = 1;
	localparam int PIT_BIT_BREAK     = 2;
	localparam int PIT_BIT_BRK_CLR   = 3;
	// Reset values, prescaler code limit and response codes
	localparam logic [15:0] PIT_MODULO_RESET = 16'hFFFF;
	localparam logic [15:0] PIT_COUNT_RESET  = 16'h0000;
	localparam logic [2:0]  PIT_PS_RESET     = 3'h0;
	localparam logic [2:0]  PIT_PS_MAX_CODE  = 3'h6;
	localparam logic [1:0]  PIT_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  PIT_RESP_SLVERR  = 2'h2;
endpackage

// ===== rtl/pit_timer.sv
`timescale 1ns/1ns
`default_nettype none
module pit_timer
	import pit_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic                  sys_clk,
	input  wire logic                  nrst,
	input  wire logic [PIT_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [PIT_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic                       irq_out
);

	if (CNT_W != 16) begin : g_bad_width
		$error("pit_timer: counter width must be 16");
	end

	////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [15:0] count_reg;
	logic [5:0]  prescale_reg;
	logic [15:0] modulo_reg;
	logic [7:0]  low_latch_reg;
	logic        low_latched_reg;
	logic        overflow_flag_reg;
	logic        flag_armed_reg;
	logic        overflow_irq_enable_reg;
	logic        counter_halt_reg;
	logic [2:0]  prescale_select_reg;
	logic        modulo_inhibit_reg;
	logic [3:0]  mode_reg;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel: address and data taken in either order
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [9:0]  aw_idx_reg;
	logic [7:0]  wdata_reg;
	logic        wlane_reg;
	logic        wr_do;
	logic [9:0]  ar_idx;
	logic        rd_do;

	// Writes to the counter bytes are accepted and dropped; only unknown indices error
	function automatic logic wr_mapped(input logic [9:0] idx);
		logic hit;
		hit = 1'b0;
		if (idx == 10'(PIT_IDX_STATUS_CONTROL)) begin
			hit = 1'b1;
		end
		if (idx == 10'(PIT_IDX_MODULO_HIGH) || idx == 10'(PIT_IDX_MODULO_LOW)) begin
			hit = 1'b1;
		end
		if (idx == 10'(PIT_IDX_COUNT_HIGH) || idx == 10'(PIT_IDX_COUNT_LOW)) begin
			hit = 1'b1;
		end
		if (idx == 10'(PIT_IDX_MODE_CONTROL)) begin
			hit = 1'b1;
		end
		wr_mapped = hit;
	endfunction

	assign wr_do = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			aw_idx_reg    <= 10'h000;
			wdata_reg     <= 8'h00;
			wlane_reg     <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= PIT_RESP_OKAY;
		end else begin
			// No new address while a response waits, keeps one write in flight
			s_axi_awready <= !aw_held_reg && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg   <= 1'b1;
				aw_idx_reg    <= s_axi_awaddr[PIT_ADDR_W-1:2];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg   <= 1'b1;
				wdata_reg    <= s_axi_wdata[7:0];
				wlane_reg    <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_do) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped(aw_idx_reg) ? PIT_RESP_OKAY : PIT_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Effective register write strobes; a cleared byte lane writes nothing
	logic wr_sc;
	logic wr_modh;
	logic wr_modl;
	logic wr_mode;
	logic cpu_off;
	assign cpu_off = mode_reg[PIT_BIT_WAIT] || mode_reg[PIT_BIT_STOP];
	assign wr_sc   = wr_do && wlane_reg && !cpu_off && aw_idx_reg == 10'(PIT_IDX_STATUS_CONTROL);
	assign wr_modh = wr_do && wlane_reg && !cpu_off && aw_idx_reg == 10'(PIT_IDX_MODULO_HIGH);
	assign wr_modl = wr_do && wlane_reg && !cpu_off && aw_idx_reg == 10'(PIT_IDX_MODULO_LOW);
	// Mode register models the system's wait/stop/break lines; always reachable
	assign wr_mode = wr_do && wlane_reg && aw_idx_reg == 10'(PIT_IDX_MODE_CONTROL);

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	assign ar_idx = s_axi_araddr[PIT_ADDR_W-1:2];
	assign rd_do  = s_axi_arvalid && s_axi_arready;

	// Unknown indices answer SLVERR with zero data
	// Reads have no side effects except arming the flag clear and the low latch
	logic [7:0] rd_byte;
	logic       rd_ok;
	always_comb begin
		rd_byte = 8'h00;
		rd_ok   = 1'b1;
		if (ar_idx == 10'(PIT_IDX_STATUS_CONTROL)) begin
			rd_byte = {overflow_flag_reg, overflow_irq_enable_reg, counter_halt_reg, 2'b00,
				prescale_select_reg};
		end else if (ar_idx == 10'(PIT_IDX_COUNT_HIGH)) begin
			rd_byte = count_reg[15:8];
		end else if (ar_idx == 10'(PIT_IDX_COUNT_LOW)) begin
			rd_byte = low_latched_reg ? low_latch_reg : count_reg[7:0];
		end else if (ar_idx == 10'(PIT_IDX_MODULO_HIGH)) begin
			rd_byte = modulo_reg[15:8];
		end else if (ar_idx == 10'(PIT_IDX_MODULO_LOW)) begin
			rd_byte = modulo_reg[7:0];
		end else if (ar_idx == 10'(PIT_IDX_MODE_CONTROL)) begin
			rd_byte = {4'h0, mode_reg};
		end else begin
			rd_ok = 1'b0;
		end
		if (cpu_off && ar_idx != 10'(PIT_IDX_MODE_CONTROL)) begin
			rd_byte = 8'h00;
		end
	end

	logic rd_sc;
	logic rd_cnth;
	logic rd_cntl;
	assign rd_sc   = rd_do && !cpu_off && ar_idx == 10'(PIT_IDX_STATUS_CONTROL);
	assign rd_cnth = rd_do && !cpu_off && ar_idx == 10'(PIT_IDX_COUNT_HIGH);
	assign rd_cntl = rd_do && !cpu_off && ar_idx == 10'(PIT_IDX_COUNT_LOW);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= PIT_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_do;
			if (rd_do) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h000000, rd_byte};
				s_axi_rresp  <= rd_ok ? PIT_RESP_OKAY : PIT_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control bits
	logic in_break;
	logic brk_protect;
	logic clr_pulse;
	assign in_break    = mode_reg[PIT_BIT_BREAK];
	assign brk_protect = in_break && !mode_reg[PIT_BIT_BRK_CLR];
	// Clear bit is write-only: it drives clr_pulse and is never stored
	assign clr_pulse   = wr_sc && wdata_reg[PIT_BIT_CLEAR];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			overflow_irq_enable_reg <= 1'b0;
			counter_halt_reg        <= 1'b1;
			prescale_select_reg     <= PIT_PS_RESET;
		end else if (wr_sc) begin
			overflow_irq_enable_reg <= wdata_reg[PIT_BIT_IRQ_EN];
			counter_halt_reg        <= wdata_reg[PIT_BIT_HALT];
			prescale_select_reg     <= wdata_reg[PIT_PS_MSB:0];
		end
	end

	// Bit 3 lets clears made during break stick
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mode_reg <= 4'h0;
		end else if (wr_mode) begin
			mode_reg <= wdata_reg[3:0];
		end
	end

	// Modulo takes effect at once; software should clear the counter first
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			modulo_reg         <= PIT_MODULO_RESET;
			modulo_inhibit_reg <= 1'b0;
		end else begin
			if (wr_modh) begin
				modulo_reg[15:8]   <= wdata_reg;
				modulo_inhibit_reg <= 1'b1;
			end
			if (wr_modl) begin
				modulo_reg[7:0]    <= wdata_reg;
				modulo_inhibit_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Prescaler and counter
	logic run;
	logic tick;
	logic match;
	// Wait mode keeps running; stop and break freeze everything
	// Stop freezes the prescaler too, so no partial tick is lost
	assign run = !counter_halt_reg && !mode_reg[PIT_BIT_STOP] && !in_break;

	logic [5:0] prescale_mask;
	// Divide by 2^n, with code 7 dividing by 64 like code 6: tick each time the low n prescaler bits are all ones
	always_comb begin
		unique case (prescale_select_reg)
			3'h0: prescale_mask = 6'h00;
			3'h1: prescale_mask = 6'h01;
			3'h2: prescale_mask = 6'h03;
			3'h3: prescale_mask = 6'h07;
			3'h4: prescale_mask = 6'h0F;
			3'h5: prescale_mask = 6'h1F;
			3'h6: prescale_mask = 6'h3F;
			3'h7: prescale_mask = 6'h3F;
		endcase
	end
	assign tick = (prescale_reg & prescale_mask) == prescale_mask;

	assign match = (count_reg == modulo_reg);

	logic [15:0] count_next;
	logic [5:0]  prescale_next;
	// Clear takes precedence, so halt plus clear parks at zero
	always_comb begin
		count_next    = count_reg;
		prescale_next = prescale_reg;
		if (clr_pulse) begin
			prescale_next = 6'h00;
			count_next    = PIT_COUNT_RESET;
		end else if (run) begin
			prescale_next = prescale_reg + 6'h01;
			if (tick) begin
				count_next = match ? PIT_COUNT_RESET : count_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prescale_reg <= 6'h00;
			count_reg    <= PIT_COUNT_RESET;
		end else begin
			prescale_reg <= prescale_next;
			count_reg    <= count_next;
		end
	end

	logic ovf_event;
	assign ovf_event = run && !clr_pulse && tick && match && !modulo_inhibit_reg;

	////////////////////////////////////////////////////////////////////////////
	// Overflow flag with two-step clear
	// Arming needs the flag seen set; a read while clear does not arm
	logic clr_req;
	assign clr_req = wr_sc && !wdata_reg[PIT_BIT_OVERFLOW] && flag_armed_reg && !brk_protect;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			overflow_flag_reg <= 1'b0;
			flag_armed_reg    <= 1'b0;
		end else if (ovf_event) begin
			// A fresh overflow beats a clear and disarms it
			overflow_flag_reg <= 1'b1;
			flag_armed_reg    <= 1'b0;
		end else if (clr_req) begin
			overflow_flag_reg <= 1'b0;
			flag_armed_reg    <= 1'b0;
		end else if (rd_sc && overflow_flag_reg && !brk_protect) begin
			flag_armed_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Low byte latch
	// A high-byte read during break still latches; software must read the low
	// byte before leaving break or the old low byte stays captured
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			low_latched_reg <= 1'b0;
			low_latch_reg   <= 8'h00;
		end else if (clr_pulse) begin
			low_latched_reg <= 1'b0;
			low_latch_reg   <= 8'h00;
		end else if (rd_cntl) begin
			low_latched_reg <= 1'b0;
		end else if (rd_cnth && !low_latched_reg) begin
			low_latched_reg <= 1'b1;
			low_latch_reg   <= count_reg[7:0];
		end
	end

	logic irq_next;
	// Level request, held until the flag is cleared or the enable dropped
	assign irq_next = overflow_flag_reg && overflow_irq_enable_reg;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= irq_next;
		end
	end

endmodule
`default_nettype wire

// ===== verification/pit_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module pit_monitor (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write not answered");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while response pending");
	a_byte_data: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data above byte");
	// Only a status write may take the request away
	a_irq_drop: assert property ($fell(irq_out) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_wvalid, 2))
		else $error("interrupt fell without write");
endmodule
bind pit_timer pit_monitor mon_u (.*);
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
	import pit_pkg::*;
;
	logic                  sys_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_out;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	logic [31:0]           s_axi_wdata, s_axi_rdata;
	logic [3:0]            s_axi_wstrb;
	logic [PIT_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	int                    cyc, checks, bad_count;
	localparam logic [7:0] SC = PIT_IDX_STATUS_CONTROL, CH = PIT_IDX_COUNT_HIGH, CL = PIT_IDX_COUNT_LOW;
	localparam logic [7:0] MH = PIT_IDX_MODULO_HIGH, ML = PIT_IDX_MODULO_LOW, MD = PIT_IDX_MODE_CONTROL;
	pit_timer dut_u (.*);
	always #25 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Each task lets an edge pass at its end so no handshake signal is set twice in one step
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		s_axi_awaddr <= {2'h0, i, 2'h0};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		chk("bresp", {30'h0, PIT_RESP_OKAY}, {30'h0, s_axi_bresp});
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rc(input logic [7:0] i, input logic [7:0] e, input string nm);
		logic [31:0] d;
		logic [1:0]  r;
		rd({2'h0, i, 2'h0}, d, r);
		chk(nm, {PIT_RESP_OKAY, 22'h000000, e}, {r, d[29:0]});
	endtask
	task automatic cnt(output logic [15:0] v);
		logic [31:0] h, l;
		logic [1:0]  r;
		rd({2'h0, CH, 2'h0}, h, r);
		rd({2'h0, CL, 2'h0}, l, r);
		v = {h[7:0], l[7:0]};
	endtask
	task automatic wirq(input logic e);
		repeat (60) if (irq_out !== e) @(posedge sys_clk);
		chk("irq_out", {31'h0, e}, {31'h0, irq_out});
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		rc(SC, 8'h20, "status reset");
		rc(MH, 8'hFF, "modulo high reset");
		rc(ML, 8'hFF, "modulo low reset");
		wr(CH, 8'h12);
		wr(SC, 8'h30);
		rc(SC, 8'h20, "clear reads zero");
		rc(CH, 8'h00, "count high");
		rc(CL, 8'h00, "count low");
		rd(12'h200, d, r);
		chk("unmapped", {30'h0, PIT_RESP_SLVERR}, {30'h0, r});
		wr(MH, 8'h5A);
		rc(MH, 8'h5A, "modulo write");
		wr(MH, 8'hFF);
	endtask
	task automatic t_prescale;
		logic [15:0] v0, v1;
		int          t0;
		for (int c = 0; c < 8; c++) begin
			wr(SC, 8'h10 | 8'(c));
			t0 = cyc;
			cnt(v0);
			while (cyc < t0 + 320) @(posedge sys_clk);
			cnt(v1);
			chk("count step", 32'h140 >> (c == 7 ? 6 : c), {16'h0000, 16'(v1 - v0)});
		end
	endtask
	task automatic t_latch;
		logic [15:0] v0;
		logic [31:0] h, l;
		logic [1:0]  r;
		int          t0;
		wr(SC, 8'h10);
		t0 = cyc;
		cnt(v0);
		while (cyc < t0 + 100) @(posedge sys_clk);
		rd({2'h0, CH, 2'h0}, h, r);
		repeat (40) @(posedge sys_clk);
		rd({2'h0, CH, 2'h0}, l, r);
		rd({2'h0, CL, 2'h0}, l, r);
		chk("latched count", 32'h64, {16'h0000, 16'({h[7:0], l[7:0]} - v0)});
	endtask
	task automatic t_overflow;
		logic [15:0] v0, v1;
		wr(SC, 8'h30);
		wr(MH, 8'h00);
		wr(ML, 8'h05);
		wr(SC, 8'h50);
		wirq(1'b1);
		wr(SC, 8'hE0);
		cnt(v0);
		repeat (8) @(posedge sys_clk);
		cnt(v1);
		chk("halted count", {16'h0000, v0}, {16'h0000, v1});
		chk("count within modulo", 32'h1, {31'h0, v0 <= 16'h0005});
		wr(SC, 8'h60);
		rc(SC, 8'hE0, "unarmed clear");
		wr(SC, 8'h60);
		rc(SC, 8'h60, "armed clear");
		wirq(1'b0);
		wr(SC, 8'h00);
		repeat (30) @(posedge sys_clk);
		chk("irq disabled", 32'h0, {31'h0, irq_out});
		wr(SC, 8'hA0);
		rc(SC, 8'hA0, "flag without irq");
		wr(SC, 8'h20);
		wr(SC, 8'h50);
		wr(MD, 8'h01);
		rc(SC, 8'h00, "wait hides regs");
		wirq(1'b1);
		wr(MD, 8'h00);
	endtask
	task automatic t_inhibit;
		wr(SC, 8'hA0);
		rc(SC, 8'hA0, "flag before inhibit");
		wr(SC, 8'h30);
		wr(MH, 8'h00);
		wr(SC, 8'h00);
		repeat (40) @(posedge sys_clk);
		wr(SC, 8'h20);
		rc(SC, 8'h20, "overflow inhibited");
		wr(ML, 8'h03);
		wr(SC, 8'h10);
		repeat (20) @(posedge sys_clk);
		wr(SC, 8'hA0);
		rc(SC, 8'hA0, "overflow after low");
	endtask
	task automatic t_break;
		logic [15:0] v0, v1;
		wr(MD, 8'h04);
		wr(SC, 8'h20);
		rc(SC, 8'hA0, "protected in break");
		wr(MD, 8'h00);
		wr(SC, 8'h20);
		rc(SC, 8'h20, "clear after break");
		wr(SC, 8'h00);
		wr(MD, 8'h0C);
		cnt(v0);
		repeat (8) @(posedge sys_clk);
		cnt(v1);
		chk("break holds count", {16'h0000, v0}, {16'h0000, v1});
		rc(SC, 8'h80, "flag in break");
		wr(SC, 8'h00);
		rc(SC, 8'h00, "cleared in break");
		wr(MD, 8'h00);
		wr(SC, 8'h17);
		wr(MD, 8'h02);
		rc(SC, 8'h00, "stop hides regs");
		repeat (200) @(posedge sys_clk);
		wr(MD, 8'h00);
		cnt(v0);
		chk("stop holds count", 32'h0, {16'h0000, v0});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{sys_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{cyc, checks, bad_count} = '0;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		t_prescale();
		t_latch();
		t_overflow();
		t_inhibit();
		t_break();
		final_report();
	end
	// Whole run needs well under this many cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
endmodule
`default_nettype wire
